/* File: src/light_prox_pkg.sv */
// constants shared by the light / proximity timing and threshold-interrupt block
// assumes a 40 MHz core clock and an external serial front end that turns bus
// transactions into single-cycle register strobes
//
// What this block does
// (RULE1) integration time register resets to 0xff, one step
// (RULE2) light integrates for 256 minus setting steps of 2.78 ms
// (RULE3) clear count clamps at lesser of 65535 and 1024 times steps plus one
// (RULE4) proximity integrates a fixed 0.696 ms, independent of light setting
// (RULE5) wait lasts 256 minus setting steps of 2.78 ms
// (RULE6) long-wait bit stretches every wait step twelve times
// (RULE7) wait time register resets to 0xff, one step
// (RULE8) host should program the wait time before enabling sensing
// (RULE9) every measurement cycle is followed by the wait state
// (RULE10) only the 16-bit clear result is compared with 16-bit thresholds
// (RULE11) enabled light interrupt fires when clear result stays outside thresholds
// (RULE12) light thresholds are built from byte registers 0x84 to 0x87
// (RULE13) proximity out of range is below 0x89 value or above 0x8b value
// (RULE14) consecutive out-of-range results are counted; an in-range one zeroes it
// (RULE15) proximity and light have their own persistence counters
// (RULE16) proximity field 0 fires every cycle, 1 to 15 after that many
// (RULE17) light field 0 every cycle, 1 to 3 direct, 4 to 15 five times value less three
// (RULE18) the wait timer runs only while the wait enable bit is one
// (RULE19) light interrupts only while the light interrupt enable is set
// (RULE20) proximity interrupts only while the proximity interrupt enable is set
// (RULE21) address-only access to the clear location drops pending flags
// (RULE22) a raised interrupt holds until the host clears it
package light_prox_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int             ADDR_W               = 8;
	localparam logic [7:0]     ADDR_ENABLE          = 8'h80;
	localparam logic [7:0]     ADDR_INTEG           = 8'h81;
	localparam logic [7:0]     ADDR_WAIT            = 8'h83;
	localparam logic [7:0]     ADDR_LLOW_LO         = 8'h84;
	localparam logic [7:0]     ADDR_LLOW_HI         = 8'h85;
	localparam logic [7:0]     ADDR_LHIGH_LO        = 8'h86;
	localparam logic [7:0]     ADDR_LHIGH_HI        = 8'h87;
	localparam logic [7:0]     ADDR_NLOW            = 8'h89;
	localparam logic [7:0]     ADDR_NHIGH           = 8'h8b;
	localparam logic [7:0]     ADDR_PERSIST         = 8'h8c;
	localparam logic [7:0]     ADDR_CONFIG1         = 8'h8d;
	localparam logic [7:0]     ADDR_STATUS          = 8'h93;
	localparam logic [7:0]     ADDR_CLEAR_LO        = 8'h94;
	localparam logic [7:0]     ADDR_CLEAR_HI        = 8'h95;
	localparam logic [7:0]     ADDR_NEAR_RESULT     = 8'h9c;
	localparam logic [7:0]     ADDR_CLR_NEAR        = 8'he5;
	localparam logic [7:0]     ADDR_CLR_LIGHT       = 8'he6;
	localparam logic [7:0]     ADDR_CLR_ALL         = 8'he7;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int             EN_POWER_BIT         = 0;
	localparam int             EN_LIGHT_BIT         = 1;
	localparam int             EN_NEAR_BIT          = 2;
	localparam int             EN_WAIT_BIT          = 3;
	localparam int             EN_LIGHT_IRQ_BIT     = 4;
	localparam int             EN_NEAR_IRQ_BIT      = 5;
	localparam int             CFG_LONG_WAIT_BIT    = 1;
	localparam int             ST_LIGHT_FLAG_BIT    = 4;
	localparam int             ST_NEAR_FLAG_BIT     = 5;
	localparam logic [7:0]     ENABLE_WR_MASK       = 8'h3f;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]     RST_ENABLE           = 8'h00;
	localparam logic [7:0]     RST_INTEG            = 8'hff;
	localparam logic [7:0]     RST_WAIT             = 8'hff;
	localparam logic [7:0]     RST_THRESH           = 8'h00;
	localparam logic [7:0]     RST_PERSIST          = 8'h00;
	localparam logic [7:0]     RST_CONFIG1          = 8'h40;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int             CLOCK_KHZ            = 40000;
	localparam int             STEP_TIME_US         = 2780;
	localparam int             NEAR_TIME_US         = 696;
	localparam int             STEP_CYCLES_DEF      = STEP_TIME_US * CLOCK_KHZ / 1000;
	localparam int             NEAR_CYCLES_DEF      = (NEAR_TIME_US * CLOCK_KHZ + 999) / 1000;
	localparam logic [3:0]     LONG_WAIT_LAST       = 4'hb;
	localparam logic [8:0]     FULL_STEPS           = 9'h100;
	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_NEAR  = 2'b01,
		SEQ_LIGHT = 2'b10,
		SEQ_WAIT  = 2'b11
	} seq_state_t;
endpackage

/* File: src/persist_filter.sv */
// persistence filter: counts consecutive out-of-range samples of one channel
// assumes sample_i is a one-cycle strobe from the sequencer on the same clock
`timescale 1ns/1ps
module persist_filter (
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	// sample
	input  wire logic       sample_i,
	input  wire logic       outside_i,
	input  wire logic [5:0] need_i,
	// qualified result
	output logic            hit_o
);
	logic [5:0] count_ff;
	logic [5:0] nxt_count;
	wire  [5:0] count_inc = (count_ff == 6'h3f) ? count_ff : count_ff + 6'h01;

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// an in-range sample zeroes the run
	assign nxt_count = !sample_i ? count_ff : (outside_i ? count_inc : 6'h00); // see (RULE14)
	// zero need fires on every sample, in range or not
	assign hit_o = sample_i && ((need_i == 6'h00) || (outside_i && count_inc >= need_i));

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			count_ff <= 6'h00;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_run_reset: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE14)
		sample_i && !outside_i |=> count_ff == 6'h00)
		else $error("persistence run not zeroed by in-range sample");
	chk_run_fire: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE16)
		sample_i && outside_i && need_i != 6'h00 && count_ff == need_i - 6'h01 |-> hit_o)
		else $error("persistence did not fire at the programmed run length");
endmodule

/* File: src/light_prox_timing.sv */
// light / proximity cycle sequencer, saturation clamp and threshold interrupts
// assumes a serial front end delivering one-cycle register strobes, and sample
// words from the converters that are valid on the clock that ends each phase
`timescale 1ns/1ps
module light_prox_timing #(
	parameter int STEP_CYCLES = light_prox_pkg::STEP_CYCLES_DEF,
	parameter int NEAR_CYCLES = light_prox_pkg::NEAR_CYCLES_DEF
) (
	// clock and reset
	input  wire logic                              clock_i,
	input  wire logic                              rst_i,
	// register strobes from the serial front end
	input  wire logic [light_prox_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic                              reg_wr_i,
	input  wire logic [7:0]                        reg_wdata_i,
	input  wire logic                              reg_rd_i,
	input  wire logic                              reg_addr_only_i,
	output logic [7:0]                             reg_rdata_o,
	// converter samples
	input  wire logic [15:0]                       light_sample_i,
	input  wire logic [7:0]                        near_sample_i,
	// converter phase controls
	output logic                                   near_integrating_o,
	output logic                                   light_integrating_o,
	output logic                                   waiting_o,
	// host interrupt, active high
	output logic                                   irq_o
);
	import light_prox_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] light_limit(input logic [8:0] steps);
		logic [18:0] v;
		v = {steps, 10'h000} + 19'h00001;
		return (v > 19'h0ffff) ? 16'hffff : v[15:0];
	endfunction

	function automatic logic [5:0] light_need(input logic [3:0] field);
		logic [5:0] d;
		d = {2'b00, field - 4'h3};
		return (field <= 4'h3) ? {2'b00, field} : (d << 2) + d;
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]  enable_ff, integ_ff, wait_ff, config1_ff, persist_ff;
	logic [7:0]  llow_lo_ff, llow_hi_ff, lhigh_lo_ff, lhigh_hi_ff;
	logic [7:0]  nlow_ff, nhigh_ff, near_result_ff, rdata_ff;
	logic [15:0] clear_ff;
	logic        light_flag_ff, near_flag_ff, irq_ff;
	logic        near_int_ff, light_int_ff, waiting_ff;
	seq_state_t  state_ff, nxt_state;
	logic [16:0] cyc_ff;
	logic [8:0]  step_ff;
	logic [3:0]  sub_ff;

	wire wr_enable  = reg_wr_i && reg_addr_i == ADDR_ENABLE;
	wire wr_integ   = reg_wr_i && reg_addr_i == ADDR_INTEG;
	wire wr_wait    = reg_wr_i && reg_addr_i == ADDR_WAIT;
	wire wr_config1 = reg_wr_i && reg_addr_i == ADDR_CONFIG1;
	wire wr_persist = reg_wr_i && reg_addr_i == ADDR_PERSIST;
	wire wr_llow_lo = reg_wr_i && reg_addr_i == ADDR_LLOW_LO;
	wire wr_llow_hi = reg_wr_i && reg_addr_i == ADDR_LLOW_HI;
	wire wr_lhi_lo  = reg_wr_i && reg_addr_i == ADDR_LHIGH_LO;
	wire wr_lhi_hi  = reg_wr_i && reg_addr_i == ADDR_LHIGH_HI;
	wire wr_nlow    = reg_wr_i && reg_addr_i == ADDR_NLOW;
	wire wr_nhigh   = reg_wr_i && reg_addr_i == ADDR_NHIGH;

	wire power_on        = enable_ff[EN_POWER_BIT];
	wire light_sense_en  = enable_ff[EN_LIGHT_BIT];
	wire near_sense_en   = enable_ff[EN_NEAR_BIT];
	wire wait_en         = enable_ff[EN_WAIT_BIT];
	wire light_irq_en    = enable_ff[EN_LIGHT_IRQ_BIT];
	wire near_irq_en     = enable_ff[EN_NEAR_IRQ_BIT];
	wire long_wait_sel   = config1_ff[CFG_LONG_WAIT_BIT];

	// ----------------------------------------------------------------
	// sequencer timing
	// ----------------------------------------------------------------
	wire [8:0] light_steps = FULL_STEPS - {1'b0, integ_ff}; // see (RULE2)
	wire [8:0] wait_steps  = FULL_STEPS - {1'b0, wait_ff}; // see (RULE5)
	wire       step_end    = cyc_ff == 17'(STEP_CYCLES - 1);
	wire       near_end    = cyc_ff == 17'(NEAR_CYCLES - 1);
	// long wait: each step repeats twelve times before it counts
	wire       wait_tick   = step_end && (!long_wait_sel || sub_ff == LONG_WAIT_LAST); // see (RULE6)
	wire       abort       = !power_on || !(light_sense_en || near_sense_en);

	wire near_done  = state_ff == SEQ_NEAR && near_end; // see (RULE4)
	wire light_done = state_ff == SEQ_LIGHT && step_end && step_ff == light_steps - 9'h001;
	// without wait enable the wait state is passed straight through
	wire wait_done  = state_ff == SEQ_WAIT &&
		(!wait_en || (wait_tick && step_ff == wait_steps - 9'h001)); // see (RULE18)
	wire start      = state_ff == SEQ_IDLE && !abort;
	wire advance    = near_done || light_done || wait_done || start || abort;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			SEQ_IDLE: begin
				if (start) begin
					nxt_state = near_sense_en ? SEQ_NEAR : SEQ_LIGHT;
				end
			end
			SEQ_NEAR: begin
				if (near_done) begin
					nxt_state = light_sense_en ? SEQ_LIGHT : SEQ_WAIT; // see (RULE9)
				end
			end
			SEQ_LIGHT: begin
				if (light_done) begin
					nxt_state = SEQ_WAIT; // see (RULE9)
				end
			end
			SEQ_WAIT: begin
				if (wait_done) begin
					nxt_state = SEQ_IDLE;
				end
			end
		endcase
		if (abort) begin
			nxt_state = SEQ_IDLE;
		end
	end

	wire        step_adv   = (state_ff == SEQ_LIGHT && step_end) ||
		(state_ff == SEQ_WAIT && wait_tick);
	wire        counting   = state_ff != SEQ_IDLE;
	wire [16:0] nxt_cyc    = (advance || !counting || (step_end && state_ff != SEQ_NEAR))
		? 17'h00000 : cyc_ff + 17'h00001;
	wire [8:0]  nxt_step   = advance ? 9'h000 : (step_adv ? step_ff + 9'h001 : step_ff);
	wire [3:0]  nxt_sub    = (advance || (step_end && sub_ff == LONG_WAIT_LAST)) ? 4'h0 :
		((state_ff == SEQ_WAIT && long_wait_sel && step_end) ? sub_ff + 4'h1 : sub_ff);

	// ----------------------------------------------------------------
	// results and thresholds
	// ----------------------------------------------------------------
	wire        light_eval    = light_done && !abort;
	wire        near_eval     = near_done && !abort;
	wire [15:0] light_cap     = light_limit(light_steps);
	wire [15:0] light_clamped = (light_sample_i > light_cap) ? light_cap : light_sample_i; // see (RULE3)
	wire [15:0] light_low     = {llow_hi_ff, llow_lo_ff}; // see (RULE12)
	wire [15:0] light_high    = {lhigh_hi_ff, lhigh_lo_ff}; // see (RULE12)
	// only the clear result is compared
	wire light_outside = light_clamped > light_high || light_clamped < light_low; // see (RULE10)
	wire near_outside  = near_sample_i < nlow_ff || near_sample_i > nhigh_ff; // see (RULE13)
	wire light_hit;
	wire near_hit;

	// separate runs: one channel's in-range result must not reset the other
	persist_filter u_light_persist ( // see (RULE15)
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.sample_i  (light_eval),
		.outside_i (light_outside),
		.need_i    (light_need(persist_ff[3:0])), // see (RULE17)
		.hit_o     (light_hit)
	);
	persist_filter u_near_persist (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.sample_i  (near_eval),
		.outside_i (near_outside),
		.need_i    ({2'b00, persist_ff[7:4]}), // see (RULE16)
		.hit_o     (near_hit)
	);

	// ----------------------------------------------------------------
	// interrupt flags
	// ----------------------------------------------------------------
	wire addr_clear     = reg_addr_only_i && reg_addr_i == ADDR_CLR_ALL;
	wire clr_light      = addr_clear || (reg_addr_only_i && reg_addr_i == ADDR_CLR_LIGHT); // see (RULE21)
	wire clr_near       = addr_clear || (reg_addr_only_i && reg_addr_i == ADDR_CLR_NEAR); // see (RULE21)
	wire light_set      = light_hit && light_irq_en; // see (RULE11), (RULE19)
	wire near_set       = near_hit && near_irq_en; // see (RULE20)
	// a set in the clearing cycle wins; flags never drop on return to range
	wire nxt_light_flag = light_set || (light_flag_ff && !clr_light); // see (RULE22)
	wire nxt_near_flag  = near_set || (near_flag_ff && !clr_near); // see (RULE22)

	// ----------------------------------------------------------------
	// register writes and reads
	// ----------------------------------------------------------------
	wire [7:0] status_w = {2'b00, near_flag_ff, light_flag_ff, 4'h0};
	wire [7:0] rd_mux =
		(reg_addr_i == ADDR_ENABLE)      ? enable_ff :
		(reg_addr_i == ADDR_INTEG)       ? integ_ff :
		(reg_addr_i == ADDR_WAIT)        ? wait_ff :
		(reg_addr_i == ADDR_LLOW_LO)     ? llow_lo_ff :
		(reg_addr_i == ADDR_LLOW_HI)     ? llow_hi_ff :
		(reg_addr_i == ADDR_LHIGH_LO)    ? lhigh_lo_ff :
		(reg_addr_i == ADDR_LHIGH_HI)    ? lhigh_hi_ff :
		(reg_addr_i == ADDR_NLOW)        ? nlow_ff :
		(reg_addr_i == ADDR_NHIGH)       ? nhigh_ff :
		(reg_addr_i == ADDR_PERSIST)     ? persist_ff :
		(reg_addr_i == ADDR_CONFIG1)     ? config1_ff :
		(reg_addr_i == ADDR_STATUS)      ? status_w :
		(reg_addr_i == ADDR_CLEAR_LO)    ? clear_ff[7:0] :
		(reg_addr_i == ADDR_CLEAR_HI)    ? clear_ff[15:8] :
		(reg_addr_i == ADDR_NEAR_RESULT) ? near_result_ff : 8'h00;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			enable_ff   <= RST_ENABLE;
			integ_ff    <= RST_INTEG; // see (RULE1)
			wait_ff     <= RST_WAIT; // see (RULE7)
			config1_ff  <= RST_CONFIG1;
			persist_ff  <= RST_PERSIST;
			llow_lo_ff  <= RST_THRESH;
			llow_hi_ff  <= RST_THRESH;
			lhigh_lo_ff <= RST_THRESH;
			lhigh_hi_ff <= RST_THRESH;
			nlow_ff     <= RST_THRESH;
			nhigh_ff    <= RST_THRESH;
		end else begin
			enable_ff   <= wr_enable ? (reg_wdata_i & ENABLE_WR_MASK) : enable_ff;
			integ_ff    <= wr_integ ? reg_wdata_i : integ_ff;
			wait_ff     <= wr_wait ? reg_wdata_i : wait_ff;
			config1_ff  <= wr_config1 ? reg_wdata_i : config1_ff;
			persist_ff  <= wr_persist ? reg_wdata_i : persist_ff;
			llow_lo_ff  <= wr_llow_lo ? reg_wdata_i : llow_lo_ff;
			llow_hi_ff  <= wr_llow_hi ? reg_wdata_i : llow_hi_ff;
			lhigh_lo_ff <= wr_lhi_lo ? reg_wdata_i : lhigh_lo_ff;
			lhigh_hi_ff <= wr_lhi_hi ? reg_wdata_i : lhigh_hi_ff;
			nlow_ff     <= wr_nlow ? reg_wdata_i : nlow_ff;
			nhigh_ff    <= wr_nhigh ? reg_wdata_i : nhigh_ff;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff       <= SEQ_IDLE;
			cyc_ff         <= 17'h00000;
			step_ff        <= 9'h000;
			sub_ff         <= 4'h0;
			clear_ff       <= 16'h0000;
			near_result_ff <= 8'h00;
			light_flag_ff  <= 1'b0;
			near_flag_ff   <= 1'b0;
			irq_ff         <= 1'b0;
			rdata_ff       <= 8'h00;
			near_int_ff    <= 1'b0;
			light_int_ff   <= 1'b0;
			waiting_ff     <= 1'b0;
		end else begin
			state_ff       <= nxt_state;
			cyc_ff         <= nxt_cyc;
			step_ff        <= nxt_step;
			sub_ff         <= nxt_sub;
			clear_ff       <= light_eval ? light_clamped : clear_ff;
			near_result_ff <= near_eval ? near_sample_i : near_result_ff;
			light_flag_ff  <= nxt_light_flag;
			near_flag_ff   <= nxt_near_flag;
			irq_ff         <= nxt_light_flag || nxt_near_flag;
			rdata_ff       <= reg_rd_i ? rd_mux : rdata_ff;
			near_int_ff    <= nxt_state == SEQ_NEAR;
			light_int_ff   <= nxt_state == SEQ_LIGHT;
			waiting_ff     <= nxt_state == SEQ_WAIT;
		end
	end

	assign reg_rdata_o         = rdata_ff;
	assign near_integrating_o  = near_int_ff;
	assign light_integrating_o = light_int_ff;
	assign waiting_o           = waiting_ff;
	assign irq_o               = irq_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [16:0] near_len_ff;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			near_len_ff <= 17'h00000;
		end else begin
			near_len_ff <= near_int_ff ? near_len_ff + 17'h00001 : 17'h00000;
		end
	end

	chk_integ_reset: assert property (@(posedge clock_i) // see (RULE1)
		$past(rst_i) |-> integ_ff == 8'hff)
		else $error("integration time not 0xff after reset");
	chk_wait_reset: assert property (@(posedge clock_i) // see (RULE7)
		$past(rst_i) |-> wait_ff == 8'hff)
		else $error("wait time not 0xff after reset");
	chk_light_steps: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE2)
		state_ff == SEQ_LIGHT && step_end && !abort && step_ff != light_steps - 9'h001
		|=> state_ff == SEQ_LIGHT && step_ff == $past(step_ff) + 9'h001)
		else $error("light phase left before its step count");
	chk_clamp_limit: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE3)
		light_eval |=> clear_ff <= $past(light_cap) && clear_ff <= $past(light_sample_i))
		else $error("clear result above saturation limit");
	chk_near_length: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE4)
		$fell(near_int_ff) && !$past(abort) |-> near_len_ff == 17'(NEAR_CYCLES))
		else $error("proximity phase length wrong");
	chk_wait_follows: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE9)
		light_eval |=> waiting_ff)
		else $error("light phase not followed by wait");
	chk_wait_holds: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE18)
		state_ff == SEQ_WAIT && wait_en && !abort && !step_end |=> state_ff == SEQ_WAIT)
		else $error("wait left mid-step");
	chk_wait_skip: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE18)
		state_ff == SEQ_WAIT && !wait_en |=> state_ff == SEQ_IDLE)
		else $error("wait held with wait timer disabled");
	chk_long_step: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE6)
		state_ff == SEQ_WAIT && long_wait_sel && step_end && sub_ff != LONG_WAIT_LAST
		&& !advance |=> step_ff == $past(step_ff))
		else $error("long wait counted a short step");
	chk_light_gate: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE19)
		$rose(light_flag_ff) |-> $past(light_irq_en) && $past(light_hit))
		else $error("light flag raised without enable or qualified hit");
	chk_near_gate: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE20)
		$rose(near_flag_ff) |-> $past(near_irq_en) && $past(near_hit))
		else $error("proximity flag raised without enable or qualified hit");
	chk_irq_hold: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE22)
		irq_ff && !reg_addr_only_i |=> irq_ff)
		else $error("interrupt dropped without a clear");
	chk_clear_all: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE21)
		addr_clear && !light_set && !near_set |=> !irq_ff && !light_flag_ff && !near_flag_ff)
		else $error("clear-all left an interrupt pending");
	chk_light_clear: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE21)
		clr_light && !light_set |=> !light_flag_ff)
		else $error("light clear left the light flag set");
	chk_near_clear: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE21)
		clr_near && !near_set |=> !near_flag_ff)
		else $error("proximity clear left the proximity flag set");
	chk_light_every: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE17)
		light_eval && light_irq_en && persist_ff[3:0] == 4'h0 |=> light_flag_ff)
		else $error("light persistence zero did not fire on a sample");
	chk_light_masked: assert property (@(posedge clock_i) disable iff (rst_i) // see (RULE19)
		!light_irq_en && !light_flag_ff |=> !light_flag_ff)
		else $error("light flag raised while light interrupts masked");

	cov_light_sample: cover property (@(posedge clock_i) disable iff (rst_i) light_eval);
	cov_irq_rise: cover property (@(posedge clock_i) disable iff (rst_i) $rose(irq_ff));
	cov_long_wait: cover property (@(posedge clock_i) disable iff (rst_i)
		state_ff == SEQ_WAIT && long_wait_sel && wait_done);
	cov_set_on_clear: cover property (@(posedge clock_i) disable iff (rst_i)
		addr_clear && (light_set || near_set));
	cov_near_flag: cover property (@(posedge clock_i) disable iff (rst_i) $rose(near_flag_ff));
endmodule

/* File: verification/host_model.sv */
// host side model: single-cycle register strobes toward the block
// assumes the block samples strobes on the shared rising clock edge
`timescale 1ns/1ps
module host_model (
	input  wire logic       clock_i,
	input  wire logic [7:0] rdata_i,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic            ao_o
);
	// k: 0 write, 1 read, 2 address-only clear; q is the read data
	task automatic acc(input int k, input logic [7:0] a, d, output logic [7:0] q);
		@(posedge clock_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= (k == 0);
		rd_o    <= (k == 1);
		ao_o    <= (k == 2);
		@(posedge clock_i);
		{wr_o, rd_o, ao_o} <= 3'h0;
		addr_o <= ~a;
		@(posedge clock_i);
		q = rdata_i;
	endtask
	initial {addr_o, wdata_o, wr_o, rd_o, ao_o} = 19'h0;
endmodule

/* File: verification/tb_light_prox_timing.sv */
// self-checking bench for the timing and threshold-interrupt block
// assumes host_model compiled first; step shortened to 20 cycles
`timescale 1ns/1ps
module tb_light_prox_timing;
	import light_prox_pkg::*;
	localparam int ST = 20;
	logic        clock_i = 0, rst_i = 1, wr, rd, ao, ni, li, wt, irq;
	logic [7:0]  a, wd, rdo, q, qh, ns;
	logic [15:0] ls, v;
	int          err_count, cmp_count, c[3], len[3], n, need;
	wire  [2:0]  ph = {wt, li, ni};
	always #12.5 clock_i = ~clock_i;
	host_model u_host_model (.clock_i(clock_i), .rdata_i(rdo), .addr_o(a),
		.wdata_o(wd), .wr_o(wr), .rd_o(rd), .ao_o(ao));
	light_prox_timing #(.STEP_CYCLES(ST), .NEAR_CYCLES(5)) u_light_prox_timing (
		.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(a), .reg_wr_i(wr),
		.reg_wdata_i(wd), .reg_rd_i(rd), .reg_addr_only_i(ao), .reg_rdata_o(rdo),
		.light_sample_i(ls), .near_sample_i(ns), .near_integrating_o(ni),
		.light_integrating_o(li), .waiting_o(wt), .irq_o(irq));
	// phase lengths, recorded when each level drops
	always @(posedge clock_i)
		foreach (c[i])
			if (ph[i]) c[i]++;
			else if (c[i] > 0) begin
				len[i] = c[i];
				c[i] = 0;
			end
	task automatic chk(input string s, input logic [15:0] e, g);
		cmp_count++;
		if (e !== g) begin
			err_count++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rdr(input logic [7:0] ad);
		u_host_model.acc(1, ad, 8'h00, q);
	endtask
	task automatic w(input logic [7:0] ad, d);
		u_host_model.acc(0, ad, d, q);
	endtask
	// wait for a light phase end and let the flag land
	task automatic ends;
		@(negedge li);
		repeat (3) @(posedge clock_i);
	endtask
	function automatic int lneed(input int p);
		return p <= 3 ? p : 5 * (p - 3);
	endfunction
	function automatic logic [15:0] lclamp(input int steps, input logic [15:0] x);
		int lim;
		lim = 1024 * steps + 1 > 65535 ? 65535 : 1024 * steps + 1;
		return x > lim ? 16'(lim) : x;
	endfunction
	task automatic give_verdict;
		if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#2250000;
		err_count++;
		give_verdict();
	end
	initial begin
		ls = 16'h0050;
		ns = 8'h40;
		n = $urandom(14550);
		repeat (8) @(posedge clock_i);
		rst_i <= 0;
		rdr(ADDR_INTEG);
		chk("integ", 16'h00ff, {8'h00, q});
		rdr(ADDR_WAIT);
		chk("wait", 16'h00ff, {8'h00, q});
		rdr(8'h82);
		chk("unmapped", 16'h0000, {8'h00, q});
		w(ADDR_WAIT, 8'hfe);
		w(ADDR_INTEG, 8'hfe);
		w(ADDR_LLOW_LO, 8'h10);
		w(ADDR_LHIGH_HI, 8'h01);
		w(ADDR_NLOW, 8'h20);
		w(ADDR_NHIGH, 8'h80);
		w(ADDR_ENABLE, 8'h3f);
		for (int k = 0; k < 6; k++) begin
			n = k < 2 ? k * 3 : 1 + $urandom % 15;
			need = lneed(n);
			w(ADDR_PERSIST, {4'h1, n[3:0]});
			ls <= 16'h0050;
			repeat (2) ends();
			u_host_model.acc(2, ADDR_CLR_ALL, 8'h00, q);
			chk("irq clr", 16'h0000, {15'h0, irq});
			v = 16'h0101 + 16'($urandom % 32'hfeff);
			ls <= v;
			n = 0;
			do begin
				ends();
				n++;
			end while (irq !== 1'b1 && n < 70);
			chk("runs", 16'(need == 0 ? 1 : need), 16'(n));
			rdr(ADDR_CLEAR_HI);
			qh = q;
			rdr(ADDR_CLEAR_LO);
			chk("clamp", lclamp(2, v), {qh, q});
			ls <= 16'h0050;
			ends();
			chk("held", 16'h0001, {15'h0, irq});
		end
		// light interrupts masked, proximity needs a run of two below its low threshold
		w(ADDR_PERSIST, 8'h21);
		w(ADDR_ENABLE, 8'h2f);
		u_host_model.acc(2, ADDR_CLR_LIGHT, 8'h00, q);
		rdr(ADDR_STATUS);
		chk("status clr", 16'h0000, {8'h00, q});
		ns <= 8'h10;
		ls <= v;
		ends();
		chk("near first", 16'h0000, {15'h0, irq});
		ends();
		rdr(ADDR_STATUS);
		chk("status near", 16'h0001 << ST_NEAR_FLAG_BIT, {8'h00, q});
		rdr(ADDR_NEAR_RESULT);
		chk("near result", 16'h0010, {8'h00, q});
		u_host_model.acc(2, ADDR_CLR_NEAR, 8'h00, q);
		chk("near clr", 16'h0000, {15'h0, irq});
		chk("near len", 16'h0005, 16'(len[0]));
		chk("light len", 16'(2 * ST), 16'(len[1]));
		chk("wait len", 16'(2 * ST), 16'(len[2]));
		w(ADDR_CONFIG1, 8'h42);
		repeat (2) @(negedge wt);
		repeat (2) @(posedge clock_i);
		chk("long wait", 16'(24 * ST), 16'(len[2]));
		give_verdict();
	end
endmodule
